// ===== inc/dma_chan_pkg.sv
package dma_chan_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int ADDR_W = 32;
    localparam int REQ_SRC_W = 6;
    localparam int PRIO_W = 3;
    localparam int ITER_W = 15;
    localparam int NBYTES_W = 16;
    localparam int SEXT_W = 5;
    localparam int ID_W = 4;
    // Descriptor defaults
    localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000;
    localparam logic [ITER_W-1:0] RST_ITER = 15'h0000;
    localparam logic [NBYTES_W-1:0] RST_NBYTES = 16'h0000;
    localparam logic [2:0] RST_SIZE = 3'h2;
    localparam logic RST_AUTO_STOP = 1'b1;
    // Identity presented on the bus; value is arbitrary
    localparam logic [ID_W-1:0] ENGINE_ID = 4'h5;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SWAP_OFF = 2'h0;
    localparam logic [1:0] LINK_NONE = 2'h0;
    localparam logic [1:0] LINK_MINOR = 2'h1;
    localparam logic [1:0] LINK_MAJOR = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] srcAddr;
        logic [ADDR_W-1:0] dstAddr;
        logic [15:0] srcOff;
        logic [15:0] dstOff;
        logic [1:0] xferSize;
        logic [NBYTES_W-1:0] minorBytes;
        logic minorOffEn;
        logic minorOffSrc;
        logic minorOffDst;
        logic [19:0] minorOff;
        logic [ITER_W-1:0] iterCount;
        logic autoStop;
        logic [ADDR_W-1:0] nextDesc;
        logic sgEn;
        logic [1:0] linkMode;
        logic [CH_W-1:0] linkCh;
    } desc_t;

    typedef struct packed {
        logic [SEXT_W-1:0] signPos;
        logic [1:0] swapSize;
        logic [1:0] accessType;
        logic [3:0] readAttr;
        logic [3:0] writeAttr;
        logic [REQ_SRC_W-1:0] reqSource;
        logic masterIdRepl;
        logic [1:0] protLevel;
        logic [PRIO_W-1:0] prio;
        logic preemptable;
        logic canPreempt;
    } chcfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [31:0] wdata;
        logic [1:0] size;
        logic [3:0] attr;
        logic [1:0] prot;
        logic [1:0] access;
        logic [ID_W-1:0] masterId;
    } busreq_t;
endpackage : dma_chan_pkg

// ===== rtl/dma_channel_transfer_control.sv
// What this block does
// [R1] Non-zero sign position extends read data from that bit; zero disables it.
// [R2] Swap bytes within selected size; swap size zero disables swapping.
// [R3] Per-channel access type is driven on every bus transaction.
// [R4] Read and write transactions carry their own attribute fields.
// [R5] Each channel picks one peripheral request line as trigger.
// [R6] Software can read per-channel bus identity and attribute information.
// [R7] Master-ID replication puts the originating master identity on transactions.
// [R8] Per-channel protection level is driven on bus transactions.
// [R9] Descriptor restore command sets all descriptor fields to defaults.
// [R10] Software must not restore defaults while the channel is transferring.
// [R11] Descriptor holds addresses, size and per-access offsets used for moves.
// [R12] Scatter-gather loads next descriptor and clears its request-disable bit.
// [R13] Enabled minor offset adds sign-extended value after each minor loop.
// [R14] Priority setting governs arbitration between channels; preemption flags are only stored and read back.
// [R15] Minor link triggers linked channel each time iteration count drops by 1.
// [R16] Major link triggers linked channel once when iteration count is exhausted.
// [R17] Software clears completion flag before changing link configuration.
// [R18] Automatic stop disables the hardware request when the major loop ends.
// [R19] Minor loop repeats read then write until minor byte count is exhausted.
// [R20] Iteration count decrements per minor loop; zero sets the completion flag.
module dma_channel_transfer_control
    import dma_chan_pkg::*;
(
    input wire logic clk, // 125 MHz
    input wire logic rst, // Synchronous, active high
    input wire logic [NUM_CH-1:0] descWrite, // Load descriptor strobe per channel
    input desc_t descIn, // Descriptor contents to load
    input wire logic [NUM_CH-1:0] descRestore, // Restore descriptor defaults
    input wire logic [NUM_CH-1:0] cfgWrite, // Load channel config strobe
    input chcfg_t cfgIn, // Channel config contents
    input wire logic [NUM_CH-1:0] reqEnableSet, // Set hardware request enable
    input wire logic [NUM_CH-1:0] doneClear, // Clear completion flag
    input wire logic [(1<<REQ_SRC_W)-1:0] periphReq, // Peripheral request lines, async
    input wire logic [ID_W-1:0] hostMasterId, // Master that set up the channel
    input wire logic [CH_W-1:0] infoSel, // Channel chosen for info readout
    input wire logic busReady, // Bus accepts current transaction
    input wire logic [31:0] busRdata, // Read data, valid with busReady on reads
    input desc_t descFetch, // Next descriptor from memory
    input wire logic descFetchValid, // Fetched descriptor valid
    output busreq_t busReq, // Current bus transaction
    output logic busValid, // Transaction pending
    output logic descFetchReq, // Request next descriptor
    output logic [ADDR_W-1:0] descFetchAddr, // Next descriptor address
    output logic [NUM_CH-1:0] reqEnable, // Hardware request enable per channel
    output logic [NUM_CH-1:0] chDone, // Completion flags
    output logic [NUM_CH-1:0] chActive, // Channel being serviced
    output logic [15:0] chInfo // Identity and attributes of infoSel channel
);
    typedef enum logic [2:0] {S_IDLE, S_READ, S_WRITE, S_MINOR_END, S_FETCH} state_t;

    desc_t desc_r [NUM_CH];
    chcfg_t cfg_r [NUM_CH];
    logic [ID_W-1:0] ownerId_r [NUM_CH];
    logic [(1<<REQ_SRC_W)-1:0] reqMeta_r, reqSync_r;
    logic [NUM_CH-1:0] linkPend_r, startPend;
    state_t state_r;
    logic [CH_W-1:0] cur_r, pick;
    logic pickValid;
    logic [NBYTES_W-1:0] bytesLeft_r;
    logic [31:0] rdShaped;

    // Sign-extend from bit pos; position zero leaves data untouched
    function automatic logic [31:0] sign_ext(input logic [31:0] d, input logic [SEXT_W-1:0] pos);
        logic [31:0] m;
        m = 32'hffff_ffff << pos;
        if (pos == '0)
            return d;
        return d[pos] ? (d | m) : (d & ~m);
    endfunction : sign_ext

    // Reverse bytes within the swap width
    function automatic logic [31:0] swap_bytes(input logic [31:0] d, input logic [1:0] sz);
        case (sz)
            2'h1: return {d[31:16], d[7:0], d[15:8]};
            2'h2: return {d[7:0], d[15:8], d[23:16], d[31:24]};
            default: return d;
        endcase
    endfunction : swap_bytes

    function automatic logic [NBYTES_W-1:0] size_bytes(input logic [1:0] sz);
        case (sz)
            SIZE_BYTE: return 16'h0001;
            SIZE_HALF: return 16'h0002;
            default: return 16'h0004;
        endcase
    endfunction : size_bytes

    // Pin inputs pass two flops; only the second stage is read
    always_ff @(posedge clk) begin
        if (rst) begin
            reqMeta_r <= '0;
            reqSync_r <= '0;
        end else begin
            reqMeta_r <= periphReq;
            reqSync_r <= reqMeta_r;
        end
    end

    // Start condition: request enabled and selected line asserted, or a pending link trigger
    always_comb begin
        for (int i = 0; i < NUM_CH; i++)
            startPend[i] = (reqEnable[i] && reqSync_r[cfg_r[i].reqSource]) || linkPend_r[i]; // [R5]
    end

    // Highest priority wins; ties go to the lower channel number
    always_comb begin
        pick = '0;
        pickValid = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (startPend[i] && (!pickValid || cfg_r[i].prio > cfg_r[pick].prio)) begin // [R14]
                pick = CH_W'(i);
                pickValid = 1'b1;
            end
        end
    end

    // Configuration registers; owner identity caught when the config is written
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (rst) begin
                cfg_r[i] <= '0;
                ownerId_r[i] <= '0;
            end else if (cfgWrite[i]) begin
                cfg_r[i] <= cfgIn; // [R3] [R4] [R8] [R14]
                ownerId_r[i] <= hostMasterId;
            end
        end
    end

    // Channel info readout: id, protection, access, preemption flags
    always_ff @(posedge clk) begin
        if (rst)
            chInfo <= '0;
        else
            chInfo <= {cfg_r[infoSel].masterIdRepl ? ownerId_r[infoSel] : ENGINE_ID,
                       cfg_r[infoSel].readAttr, cfg_r[infoSel].protLevel,
                       cfg_r[infoSel].accessType, cfg_r[infoSel].canPreempt,
                       cfg_r[infoSel].preemptable, chActive[infoSel], chDone[infoSel]}; // [R6]
    end

    // Read data shaped for the write: swap first, then sign extension, so the sign bit is the swapped one
    always_comb begin
        rdShaped = sign_ext(swap_bytes(busRdata, cfg_r[cur_r].swapSize), cfg_r[cur_r].signPos); // [R1] [R2]
    end

    // Main transfer engine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= S_IDLE;
            cur_r <= '0;
            bytesLeft_r <= '0;
            busValid <= 1'b0;
            busReq <= '0;
            descFetchReq <= 1'b0;
            descFetchAddr <= '0;
            chActive <= '0;
            chDone <= '0;
            reqEnable <= '0;
            linkPend_r <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                desc_r[i] <= '0;
                desc_r[i].xferSize <= RST_SIZE[1:0];
                desc_r[i].autoStop <= RST_AUTO_STOP;
            end
        end else begin
            // Software side: clears lose to a same-cycle hardware set below
            for (int i = 0; i < NUM_CH; i++) begin
                if (doneClear[i])
                    chDone[i] <= 1'b0;
                if (reqEnableSet[i])
                    reqEnable[i] <= 1'b1;
                if (descRestore[i]) begin // [R9]
                    desc_r[i] <= '0;
                    desc_r[i].srcAddr <= RST_ADDR;
                    desc_r[i].dstAddr <= RST_ADDR;
                    desc_r[i].iterCount <= RST_ITER;
                    desc_r[i].minorBytes <= RST_NBYTES;
                    desc_r[i].xferSize <= RST_SIZE[1:0];
                    desc_r[i].autoStop <= RST_AUTO_STOP;
                end else if (descWrite[i]) begin
                    desc_r[i] <= descIn; // [R11]
                end
            end
            case (state_r)
                S_IDLE: begin
                    if (pickValid) begin
                        cur_r <= pick;
                        chActive[pick] <= 1'b1;
                        linkPend_r[pick] <= 1'b0;
                        bytesLeft_r <= desc_r[pick].minorBytes;
                        state_r <= S_READ;
                        busValid <= 1'b1;
                        busReq.addr <= desc_r[pick].srcAddr;
                        busReq.write <= 1'b0;
                        busReq.wdata <= '0;
                        busReq.size <= desc_r[pick].xferSize;
                        busReq.attr <= cfg_r[pick].readAttr; // [R4]
                        busReq.prot <= cfg_r[pick].protLevel; // [R8]
                        busReq.access <= cfg_r[pick].accessType; // [R3]
                        busReq.masterId <= cfg_r[pick].masterIdRepl ? ownerId_r[pick] : ENGINE_ID; // [R7]
                    end
                end
                S_READ: begin
                    if (busReady) begin
                        busReq.addr <= desc_r[cur_r].dstAddr;
                        busReq.write <= 1'b1;
                        busReq.wdata <= rdShaped; // [R1] [R2]
                        busReq.attr <= cfg_r[cur_r].writeAttr; // [R4]
                        desc_r[cur_r].srcAddr <= desc_r[cur_r].srcAddr
                            + {{16{desc_r[cur_r].srcOff[15]}}, desc_r[cur_r].srcOff}; // [R11]
                        state_r <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (busReady) begin
                        desc_r[cur_r].dstAddr <= desc_r[cur_r].dstAddr
                            + {{16{desc_r[cur_r].dstOff[15]}}, desc_r[cur_r].dstOff};
                        if (bytesLeft_r > size_bytes(desc_r[cur_r].xferSize)) begin // [R19]
                            bytesLeft_r <= bytesLeft_r - size_bytes(desc_r[cur_r].xferSize);
                            busReq.addr <= desc_r[cur_r].srcAddr;
                            busReq.write <= 1'b0;
                            busReq.attr <= cfg_r[cur_r].readAttr;
                            state_r <= S_READ;
                        end else begin
                            bytesLeft_r <= '0;
                            busValid <= 1'b0;
                            state_r <= S_MINOR_END;
                        end
                    end
                end
                S_MINOR_END: begin
                    if (desc_r[cur_r].minorOffEn) begin // [R13]
                        if (desc_r[cur_r].minorOffSrc)
                            desc_r[cur_r].srcAddr <= desc_r[cur_r].srcAddr
                                + {{12{desc_r[cur_r].minorOff[19]}}, desc_r[cur_r].minorOff};
                        if (desc_r[cur_r].minorOffDst)
                            desc_r[cur_r].dstAddr <= desc_r[cur_r].dstAddr
                                + {{12{desc_r[cur_r].minorOff[19]}}, desc_r[cur_r].minorOff};
                    end
                    desc_r[cur_r].iterCount <= desc_r[cur_r].iterCount - 15'h0001; // [R20]
                    if (desc_r[cur_r].linkMode == LINK_MINOR && desc_r[cur_r].iterCount > 15'h0001)
                        linkPend_r[desc_r[cur_r].linkCh] <= 1'b1; // [R15]
                    if (desc_r[cur_r].iterCount <= 15'h0001) begin
                        chDone[cur_r] <= 1'b1; // [R20]
                        if (desc_r[cur_r].linkMode != LINK_NONE)
                            linkPend_r[desc_r[cur_r].linkCh] <= 1'b1; // [R16] [R15]
                        if (desc_r[cur_r].autoStop)
                            reqEnable[cur_r] <= 1'b0; // [R18]
                        if (desc_r[cur_r].sgEn) begin
                            descFetchReq <= 1'b1;
                            descFetchAddr <= desc_r[cur_r].nextDesc;
                            state_r <= S_FETCH;
                        end else begin
                            chActive[cur_r] <= 1'b0;
                            state_r <= S_IDLE;
                        end
                    end else begin
                        chActive[cur_r] <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_FETCH: begin
                    if (descFetchValid) begin
                        desc_r[cur_r] <= descFetch; // [R12]
                        desc_r[cur_r].autoStop <= 1'b0; // [R12]
                        reqEnable[cur_r] <= 1'b1;
                        descFetchReq <= 1'b0;
                        chActive[cur_r] <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule : dma_channel_transfer_control

// ===== tb/dma_ctc_props.sv
module dma_ctc_props
    import dma_chan_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic [NUM_CH-1:0] doneClear, // Done clear
    input wire logic descFetchValid, // Fetch return
    input wire busreq_t busReq, // Transaction
    input wire logic busValid, // Pending
    input wire logic busReady, // Accept
    input wire logic descFetchReq, // Fetch request
    input wire logic [ADDR_W-1:0] descFetchAddr, // Fetch address
    input wire logic [NUM_CH-1:0] reqEnable, // Enables
    input wire logic [NUM_CH-1:0] chDone, // Done flags
    input wire logic [NUM_CH-1:0] chActive // Serviced
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Steps of one data move
    sequence s_read_done;
        busValid && busReady && !busReq.write;
    endsequence
    sequence s_write_done;
        busValid && busReady && busReq.write;
    endsequence
    a_busreq_stable: assert property (busValid && !busReady |=> busValid && $stable(busReq))
        else $error("bus request changed before accept");
    a_read_then_write: assert property (s_read_done |=> busValid && busReq.write)
        else $error("read not followed by write");
    a_write_then_read: assert property (s_write_done |=> !busValid || !busReq.write)
        else $error("write followed by write");
    a_one_active: assert property ($onehot0(chActive))
        else $error("several channels active");
    a_bus_needs_active: assert property (busValid |-> (chActive != '0))
        else $error("bus traffic with no active channel");
    a_fetch_hold: assert property (descFetchReq && !descFetchValid |=> descFetchReq && $stable(descFetchAddr))
        else $error("fetch request dropped early");
    a_fetch_reenable: assert property (descFetchReq && descFetchValid |-> ##[1:3] (reqEnable != '0))
        else $error("request not enabled after fetch");
    a_done_hold: assert property (1'b1 |=> ((($past(chDone) & ~$past(doneClear)) & ~chDone) == '0))
        else $error("done flag lost without clear");
    // Reset must be watched while it is asserted, so no disable here
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !busValid && chDone == '0 && reqEnable == '0)
        else $error("outputs not idle after reset");
endmodule : dma_ctc_props

bind dma_channel_transfer_control dma_ctc_props u_props (
    .clk(clk), .rst(rst), .doneClear(doneClear), .descFetchValid(descFetchValid),
    .busReq(busReq), .busValid(busValid), .busReady(busReady), .descFetchReq(descFetchReq),
    .descFetchAddr(descFetchAddr), .reqEnable(reqEnable), .chDone(chDone), .chActive(chActive)
);

// ===== tb/bus_partner.sv
module bus_partner
    import dma_chan_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire busreq_t busReq, // Transaction
    input wire logic busValid, // Pending
    input wire logic descFetchReq, // Fetch request
    input wire desc_t nextImage, // Descriptor to return
    output logic busReady, // Accept
    output logic [31:0] busRdata, // Read data
    output desc_t descFetch, // Fetched descriptor
    output logic descFetchValid // Fetch valid
);
    timeunit 1ns;
    timeprecision 1ps;
    busreq_t obs[$];
    logic [1:0] waitCnt;
    logic slow;
    // Alternate prompt and slow answers; idle data toggles so stale values never match
    always @(posedge clk) begin
        busReady <= 1'b0;
        descFetchValid <= 1'b0;
        busRdata <= ~busRdata;
        descFetch <= ~descFetch;
        if (rst) begin
            busRdata <= 32'h0;
            waitCnt <= 2'h0;
            slow <= 1'b0;
        end else if (busValid && !busReady) begin
            if (waitCnt == 2'h0) begin
                busReady <= 1'b1;
                busRdata <= {busReq.addr[15:0], ~busReq.addr[15:0]};
                waitCnt <= slow ? 2'h3 : 2'h0;
                slow <= ~slow;
            end else waitCnt <= waitCnt - 2'h1;
        end else if (descFetchReq && !descFetchValid) begin
            descFetchValid <= 1'b1;
            descFetch <= nextImage;
        end
        // Log each accepted transaction; data of reads is not meaningful
        if (!rst && busValid && busReady) obs.push_back(busReq.write ? busReq : {busReq[78:47], 1'b0, 32'h0, busReq[13:0]});
    end
endmodule : bus_partner

// ===== tb/testbench.sv
module testbench
    import dma_chan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst, descFetchValid, busReady, busValid, descFetchReq;
    logic [3:0] descWrite, descRestore, cfgWrite, reqEnableSet, doneClear, hostMasterId, reqEnable, chDone, chActive;
    logic [63:0] periphReq;
    logic [1:0] infoSel;
    logic [31:0] busRdata, descFetchAddr, r;
    logic [15:0] chInfo;
    desc_t descIn, descFetch, nextImage, d0, d1;
    chcfg_t cfgIn, c0, c1;
    busreq_t busReq, expQ[$];
    int err_total = 0, check_count = 0, seed = 32'h842fef44;
    dma_channel_transfer_control uut (.clk(clk), .rst(rst), .descWrite(descWrite), .descIn(descIn),
        .descRestore(descRestore), .cfgWrite(cfgWrite), .cfgIn(cfgIn), .reqEnableSet(reqEnableSet),
        .doneClear(doneClear), .periphReq(periphReq), .hostMasterId(hostMasterId), .infoSel(infoSel),
        .busReady(busReady), .busRdata(busRdata), .descFetch(descFetch), .descFetchValid(descFetchValid),
        .busReq(busReq), .busValid(busValid), .descFetchReq(descFetchReq), .descFetchAddr(descFetchAddr),
        .reqEnable(reqEnable), .chDone(chDone), .chActive(chActive), .chInfo(chInfo));
    bus_partner partner (.clk(clk), .rst(rst), .busReq(busReq), .busValid(busValid), .descFetchReq(descFetchReq),
        .nextImage(nextImage), .busReady(busReady), .busRdata(busRdata), .descFetch(descFetch),
        .descFetchValid(descFetchValid));
    always #4 clk = ~clk;
    task check(input logic [79:0] seen, input logic [79:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Byte swap first, then sign extension from the chosen bit
    function automatic logic [31:0] shape(logic [31:0] rd, chcfg_t c);
        logic [31:0] v = rd;
        if (c.swapSize == 2'h1) v = {rd[31:16], rd[7:0], rd[15:8]};
        if (c.swapSize == 2'h2) v = {rd[7:0], rd[15:8], rd[23:16], rd[31:24]};
        for (int b = 1; b < 32; b++) if (c.signPos != 0 && b > c.signPos) v[b] = v[c.signPos];
        return v;
    endfunction : shape
    // Reference model: word moves, offsets per access, minor offset per loop
    task model(input desc_t d, input chcfg_t c, input logic [3:0] id);
        logic [31:0] s, t;
        busreq_t e;
        s = d.srcAddr;
        t = d.dstAddr;
        for (int i = 0; i < d.iterCount; i++) begin
            for (int p = 0; p < d.minorBytes / 4; p++) begin
                e = '{s, 1'b0, 32'h0, d.xferSize, c.readAttr, c.protLevel, c.accessType, c.masterIdRepl ? id : ENGINE_ID};
                expQ.push_back(e);
                e = '{t, 1'b1, shape({s[15:0], ~s[15:0]}, c), d.xferSize, c.writeAttr, e.prot, e.access, e.masterId};
                expQ.push_back(e);
                s += {{16{d.srcOff[15]}}, d.srcOff};
                t += {{16{d.dstOff[15]}}, d.dstOff};
            end
            if (d.minorOffEn && d.minorOffSrc) s += {{12{d.minorOff[19]}}, d.minorOff};
            if (d.minorOffEn && d.minorOffDst) t += {{12{d.minorOff[19]}}, d.minorOff};
        end
    endtask : model
    task load(input int ch, input desc_t d, input chcfg_t c, input logic [3:0] id);
        @(posedge clk);
        descWrite <= 4'h1 << ch;
        cfgWrite <= 4'h1 << ch;
        descIn <= d;
        cfgIn <= c;
        hostMasterId <= id;
        @(posedge clk);
        descWrite <= 4'h0;
        cfgWrite <= 4'h0;
        model(d, c, id);
    endtask : load
    task compare_bus;
        check(partner.obs.size(), expQ.size());
        foreach (expQ[i]) if (i < partner.obs.size()) check(partner.obs[i], expQ[i]);
        partner.obs.delete();
        expQ.delete();
    endtask : compare_bus
    // Waits for channel 2 to reach the given activity level, bounded
    task wait_active(input logic lvl);
        repeat (100) begin
            @(posedge clk);
            if (chActive[2] === lvl) break;
        end
    endtask : wait_active
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    initial begin
        #200us;
        err_total++;
        complete_run();
    end
    initial begin
        {rst, descWrite, descRestore, cfgWrite, reqEnableSet, doneClear, hostMasterId, infoSel} = '1;
        {descWrite, descRestore, cfgWrite, reqEnableSet, doneClear, infoSel, periphReq} = '0;
        {descIn, cfgIn, nextImage} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({busValid, reqEnable, chDone, chActive, descFetchReq}, 0);
        $display("reset test done");
        r = $random(seed);
        // Channel 0 runs three minor loops and then hands over to channel 1
        d0 = '{r & 32'hfff0, 32'h2000_0100, 16'h0004, 16'hfffc, SIZE_WORD, 16'h8, 1'b1, 1'b1, 1'b0, 20'hffff0,
            15'h3, 1'b1, 32'h0, 1'b0, LINK_MAJOR, 2'h1};
        c0 = '{5'd15, 2'h2, r[17:16], r[21:18], r[25:22], 6'h09, 1'b1, r[27:26], 3'h3, 1'b0, 1'b1};
        // One link trigger runs one minor loop, so the linked channel gets a single iteration
        d1 = '{32'h3000_0000, 32'h3000_1000, 16'h4, 16'h4, SIZE_WORD, 16'h4, 1'b0, 1'b0, 1'b0, 20'h0, 15'h1, 1'b1,
            32'h0, 1'b0, LINK_NONE, 2'h0};
        c1 = '{5'd0, SWAP_OFF, r[29:28], r[3:0], r[7:4], 6'h3f, 1'b0, r[9:8], 3'h1, 1'b1, 1'b0};
        load(0, d0, c0, r[31:28]);
        load(1, d1, c1, r[11:8]);
        reqEnableSet <= 4'h1;
        periphReq[9] <= 1'b1;
        @(posedge clk);
        reqEnableSet <= 4'h0;
        repeat (3000) begin
            @(posedge clk);
            if (chDone[1] === 1'b1) break;
        end
        periphReq <= '0;
        compare_bus();
        check({chDone, reqEnable}, 8'h30);
        infoSel <= 2'h0;
        repeat (2) @(posedge clk);
        check(chInfo, {r[31:28], c0.readAttr, c0.protLevel, c0.accessType,
            c0.canPreempt, c0.preemptable, 2'b01});
        doneClear <= 4'hf;
        @(posedge clk);
        doneClear <= 4'h0;
        descRestore <= 4'h1;
        @(posedge clk);
        descRestore <= 4'h0;
        @(posedge clk);
        check(chDone, 4'h0);
        $display("link test done");
        // Channel 2 finishes one pair and fetches its next descriptor
        d0 = '{32'h4000_0000, 32'h4000_0800, 16'h4, 16'h4, SIZE_WORD, 16'h4, 1'b0, 1'b0, 1'b0, 20'h0, 15'h1,
            1'b1, r & 32'hffe0, 1'b1, LINK_NONE, 2'h0};
        c0.swapSize = 2'h1;
        c0.signPos = 5'd7;
        c0.reqSource = 6'h21;
        nextImage <= d1;
        load(2, d0, c0, r[7:4]);
        reqEnableSet <= 4'h4;
        periphReq[33] <= 1'b1;
        @(posedge clk);
        reqEnableSet <= 4'h0;
        wait_active(1'b1);
        // Request drops while the pair runs, so the fetched descriptor waits for a fresh request
        periphReq <= '0;
        repeat (500) begin
            @(posedge clk);
            if (descFetchReq === 1'b1) break;
        end
        check(descFetchAddr, d0.nextDesc);
        repeat (6) @(posedge clk);
        check(reqEnable[2], 1'b1);
        // Fetched descriptor runs under the same settings; its auto stop must be cleared
        model(d1, c0, r[7:4]);
        periphReq[33] <= 1'b1;
        wait_active(1'b1);
        periphReq <= '0;
        wait_active(1'b0);
        check(reqEnable[2], 1'b1);
        compare_bus();
        $display("scatter test done");
        complete_run();
    end
endmodule : testbench
